// File: design/dbc_comparators.sv
// Debug bus comparators: register file and match logic for comparators A, B and D
//
// Notes on behaviour
// - Data mask of A is four bytes, lowest address holds the top byte.
// - Clear mask bit excludes a data bit; set bit compares it.
// - All comparator registers read anytime, writable only while not armed.
// - Opcode select set compares program counter and ignores access type.
// - Read/write value bit: 0 matches writes, 1 matches reads.
// - Access type enable set includes read/write signal; ignored in opcode mode.
// - Enable bit clear makes the comparator produce no match.
// - Access type checked only when enabled; bus level must equal value bit.
// - In A/B range mode comparator B takes A's control settings.
// - In C/D range mode comparator D takes C's control settings.
// - Comparator B holds a 24-bit address over three byte registers.
// - Comparator D holds 24-bit address, high to low, cleared at reset.
// - A's data value bits count only where the mask bit is one.
// - Setting arm in debug control one arms the unit and locks writes.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module dbc_comparators
	import dbc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [BUS_AW-1:0] bus_addr_i,
	input wire logic [BUS_DW-1:0] bus_data_i,
	input wire logic bus_rw_i,
	input wire logic bus_valid_i,
	input wire logic [BUS_AW-1:0] pc_addr_i,
	input wire logic pc_valid_i,
	output logic armed_o,
	output logic match_a_o,
	output logic match_b_o,
	output logic match_d_o
);

	logic [7:0] dbg_ctl_one_reg;
	logic [7:0] pair_mode_reg;
	logic [7:0] a_ctl_reg;
	logic [7:0] b_ctl_reg;
	logic [7:0] c_ctl_reg;
	logic [7:0] d_ctl_reg;
	logic [31:0] a_mask_reg;
	logic [31:0] a_data_reg;
	logic [BUS_AW-1:0] a_addr_reg;
	logic [BUS_AW-1:0] b_addr_reg;
	logic [BUS_AW-1:0] d_addr_reg;
	logic wr_ok;
	logic a_hit;
	logic b_hit;
	logic d_hit;
	logic [7:0] b_eff_ctl;
	logic [7:0] d_eff_ctl;

	// Byte index within a multi-byte register, lowest offset is most significant
	function automatic logic [1:0] byte_idx(input logic [15:0] addr, input logic [15:0] base);
		logic [15:0] diff;
		diff = addr - base;
		byte_idx = diff[1:0];
	endfunction

	// Qualify one comparator: enable, opcode or data address, optional access type
	function automatic logic qualify(input logic [7:0] ctl, input logic [BUS_AW-1:0] cmp,
			input logic [BUS_AW-1:0] daddr, input logic dvalid, input logic rw,
			input logic [BUS_AW-1:0] pc, input logic pvalid);
		logic ok;
		ok = 1'b0;
		if (ctl[FLD_COMP_EN]) begin
			if (ctl[FLD_OPCODE_SEL]) begin
				ok = pvalid && (pc == cmp);
			end else begin
				ok = dvalid && (daddr == cmp);
				if (ctl[FLD_ACCESS_EN] && (rw != ctl[FLD_RW_VALUE])) begin
					ok = 1'b0;
				end
			end
		end
		qualify = ok;
	endfunction

	// Writes are refused while the unit is armed
	assign wr_ok = reg_write_i && !dbg_ctl_one_reg[FLD_ARM];

	// Arm control is always writable; pair mode locks like the comparator registers
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			dbg_ctl_one_reg <= RST_BYTE;
			pair_mode_reg <= RST_BYTE;
		end else if (reg_write_i) begin
			if (reg_addr_i == OFS_DEBUG_CONTROL_ONE) begin
				dbg_ctl_one_reg <= reg_wdata_i;
			end
			if (reg_addr_i == OFS_PAIR_MODE && wr_ok) begin
				pair_mode_reg <= reg_wdata_i;
			end
		end
	end

	// Control registers of the four comparators
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			a_ctl_reg <= RST_BYTE;
			b_ctl_reg <= RST_BYTE;
			c_ctl_reg <= RST_BYTE;
			d_ctl_reg <= RST_BYTE;
		end else if (wr_ok) begin
			case (reg_addr_i)
				OFS_A_CTL: a_ctl_reg <= reg_wdata_i & CTL_WMASK;
				OFS_B_CTL: b_ctl_reg <= reg_wdata_i & CTL_WMASK;
				OFS_C_CTL: c_ctl_reg <= reg_wdata_i & CTL_WMASK;
				OFS_D_CTL: d_ctl_reg <= reg_wdata_i & CTL_WMASK;
				default: ;
			endcase
		end
	end

	// Data value and data mask of comparator A, byte wide access
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			a_mask_reg <= RST_WORD;
			a_data_reg <= RST_WORD;
		end else if (wr_ok) begin
			if (reg_addr_i >= OFS_A_MASK0 && reg_addr_i <= OFS_A_MASK3) begin
				case (byte_idx(reg_addr_i, OFS_A_MASK0))
					2'h0: a_mask_reg[31:24] <= reg_wdata_i;
					2'h1: a_mask_reg[23:16] <= reg_wdata_i;
					2'h2: a_mask_reg[15:8] <= reg_wdata_i;
					default: a_mask_reg[7:0] <= reg_wdata_i;
				endcase
			end
			if (reg_addr_i >= OFS_A_DATA0 && reg_addr_i <= OFS_A_DATA3) begin
				case (byte_idx(reg_addr_i, OFS_A_DATA0))
					2'h0: a_data_reg[31:24] <= reg_wdata_i;
					2'h1: a_data_reg[23:16] <= reg_wdata_i;
					2'h2: a_data_reg[15:8] <= reg_wdata_i;
					default: a_data_reg[7:0] <= reg_wdata_i;
				endcase
			end
		end
	end

	// Compare addresses of comparators B and D, high byte at the lowest offset
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			b_addr_reg <= RST_ADDR;
			d_addr_reg <= RST_ADDR;
		end else if (wr_ok) begin
			if (reg_addr_i >= OFS_B_ADDRH && reg_addr_i <= OFS_B_ADDRL) begin
				case (byte_idx(reg_addr_i, OFS_B_ADDRH))
					2'h0: b_addr_reg[23:16] <= reg_wdata_i;
					2'h1: b_addr_reg[15:8] <= reg_wdata_i;
					default: b_addr_reg[7:0] <= reg_wdata_i;
				endcase
			end
			if (reg_addr_i >= OFS_D_ADDRH && reg_addr_i <= OFS_D_ADDRL) begin
				case (byte_idx(reg_addr_i, OFS_D_ADDRH))
					2'h0: d_addr_reg[23:16] <= reg_wdata_i;
					2'h1: d_addr_reg[15:8] <= reg_wdata_i;
					default: d_addr_reg[7:0] <= reg_wdata_i;
				endcase
			end
		end
	end

	// Comparator A address is held at the neighbouring locations 0x115..0x117
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			a_addr_reg <= RST_ADDR;
		end else if (wr_ok && reg_addr_i >= (OFS_A_CTL + 16'h0005)
				&& reg_addr_i <= (OFS_A_CTL + 16'h0007)) begin
			case (byte_idx(reg_addr_i, OFS_A_CTL + 16'h0005))
				2'h0: a_addr_reg[23:16] <= reg_wdata_i;
				2'h1: a_addr_reg[15:8] <= reg_wdata_i;
				default: a_addr_reg[7:0] <= reg_wdata_i;
			endcase
		end
	end

	// Range mode hands the partner's control settings to B and D
	assign b_eff_ctl = (pair_mode_reg[FLD_PAIR_AB +: 2] == PAIR_RANGE) ? a_ctl_reg : b_ctl_reg;
	assign d_eff_ctl = (pair_mode_reg[FLD_PAIR_CD +: 2] == PAIR_RANGE) ? c_ctl_reg : d_ctl_reg;

	// Address qualification plus masked data compare for A
	always_comb begin
		a_hit = qualify(a_ctl_reg, a_addr_reg, bus_addr_i, bus_valid_i, bus_rw_i,
			pc_addr_i, pc_valid_i);
		if (!a_ctl_reg[FLD_OPCODE_SEL] && (((bus_data_i ^ a_data_reg) & a_mask_reg) != RST_WORD)) begin
			a_hit = 1'b0;
		end
		b_hit = qualify(b_eff_ctl, b_addr_reg, bus_addr_i, bus_valid_i, bus_rw_i,
			pc_addr_i, pc_valid_i);
		d_hit = qualify(d_eff_ctl, d_addr_reg, bus_addr_i, bus_valid_i, bus_rw_i,
			pc_addr_i, pc_valid_i);
	end

	// Registered match outputs
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			match_a_o <= 1'b0;
			match_b_o <= 1'b0;
			match_d_o <= 1'b0;
			armed_o <= 1'b0;
		end else begin
			match_a_o <= a_hit;
			match_b_o <= b_hit;
			match_d_o <= d_hit;
			armed_o <= dbg_ctl_one_reg[FLD_ARM];
		end
	end

	// Read data stand in the cycle after the read strobe; unmapped reads return zero
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= RST_BYTE;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				OFS_DEBUG_CONTROL_ONE: reg_rdata_o <= dbg_ctl_one_reg;
				OFS_PAIR_MODE: reg_rdata_o <= pair_mode_reg;
				OFS_MATCH_STATUS: reg_rdata_o <= {5'h00, match_d_o, match_b_o, match_a_o};
				OFS_A_CTL: reg_rdata_o <= a_ctl_reg;
				OFS_B_CTL: reg_rdata_o <= b_ctl_reg;
				OFS_C_CTL: reg_rdata_o <= c_ctl_reg;
				OFS_D_CTL: reg_rdata_o <= d_ctl_reg;
				OFS_A_CTL + 16'h0005: reg_rdata_o <= a_addr_reg[23:16];
				OFS_A_CTL + 16'h0006: reg_rdata_o <= a_addr_reg[15:8];
				OFS_A_CTL + 16'h0007: reg_rdata_o <= a_addr_reg[7:0];
				OFS_A_DATA0: reg_rdata_o <= a_data_reg[31:24];
				OFS_A_DATA0 + 16'h0001: reg_rdata_o <= a_data_reg[23:16];
				OFS_A_DATA0 + 16'h0002: reg_rdata_o <= a_data_reg[15:8];
				OFS_A_DATA3: reg_rdata_o <= a_data_reg[7:0];
				OFS_A_MASK0: reg_rdata_o <= a_mask_reg[31:24];
				OFS_A_MASK0 + 16'h0001: reg_rdata_o <= a_mask_reg[23:16];
				OFS_A_MASK0 + 16'h0002: reg_rdata_o <= a_mask_reg[15:8];
				OFS_A_MASK3: reg_rdata_o <= a_mask_reg[7:0];
				OFS_B_ADDRH: reg_rdata_o <= b_addr_reg[23:16];
				OFS_B_ADDRH + 16'h0001: reg_rdata_o <= b_addr_reg[15:8];
				OFS_B_ADDRL: reg_rdata_o <= b_addr_reg[7:0];
				OFS_D_ADDRH: reg_rdata_o <= d_addr_reg[23:16];
				OFS_D_ADDRH + 16'h0001: reg_rdata_o <= d_addr_reg[15:8];
				OFS_D_ADDRL: reg_rdata_o <= d_addr_reg[7:0];
				default: reg_rdata_o <= RST_BYTE;
			endcase
		end else begin
			reg_rdata_o <= RST_BYTE;
		end
	end

	// Assertions
	AST_LOCKED_MASK: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && dbg_ctl_one_reg[FLD_ARM]) |=> $stable(a_mask_reg))
		else $error("Mask changed while armed");
	AST_LOCKED_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && dbg_ctl_one_reg[FLD_ARM]) |=> $stable(b_addr_reg) && $stable(d_addr_reg))
		else $error("Address changed while armed");
	AST_MASK_HIGH_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_A_MASK0) |=> a_mask_reg[31:24] == $past(reg_wdata_i))
		else $error("Mask top byte not written");
	AST_D_LOW_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_D_ADDRL) |=> d_addr_reg[7:0] == $past(reg_wdata_i))
		else $error("D low address byte not written");
	AST_B_HIGH_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_B_ADDRH) |=> b_addr_reg[23:16] == $past(reg_wdata_i))
		else $error("B high address byte not written");
	AST_DISABLED_NO_MATCH: assert property (@(posedge mclk_i) disable iff (reset_i)
		!b_eff_ctl[FLD_COMP_EN] |=> !match_b_o)
		else $error("Disabled comparator matched");
	AST_RW_QUAL: assert property (@(posedge mclk_i) disable iff (reset_i)
		(d_eff_ctl[FLD_COMP_EN] && !d_eff_ctl[FLD_OPCODE_SEL] && d_eff_ctl[FLD_ACCESS_EN]
		&& bus_rw_i != d_eff_ctl[FLD_RW_VALUE]) |=> !match_d_o)
		else $error("Access type mismatch matched");
	AST_MASKED_DATA: assert property (@(posedge mclk_i) disable iff (reset_i)
		(!a_ctl_reg[FLD_OPCODE_SEL] && ((bus_data_i ^ a_data_reg) & a_mask_reg) != RST_WORD)
		|=> !match_a_o)
		else $error("Masked data mismatch matched");
	AST_OPCODE_MATCH: assert property (@(posedge mclk_i) disable iff (reset_i)
		(b_eff_ctl[FLD_COMP_EN] && b_eff_ctl[FLD_OPCODE_SEL] && pc_valid_i
		&& pc_addr_i == b_addr_reg) |=> match_b_o)
		else $error("Opcode address match missed");
	AST_RANGE_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		(pair_mode_reg[FLD_PAIR_AB +: 2] == PAIR_RANGE && !a_ctl_reg[FLD_COMP_EN])
		|=> !match_b_o)
		else $error("Range mode did not use A control");
	AST_RANGE_D: assert property (@(posedge mclk_i) disable iff (reset_i)
		(pair_mode_reg[FLD_PAIR_CD +: 2] == PAIR_RANGE && !c_ctl_reg[FLD_COMP_EN])
		|=> !match_d_o)
		else $error("Range mode did not use C control");
	AST_ARM: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && reg_addr_i == OFS_DEBUG_CONTROL_ONE && reg_wdata_i[FLD_ARM]) |=> ##1 armed_o)
		else $error("Arm not reflected");
	AST_DISARM: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && reg_addr_i == OFS_DEBUG_CONTROL_ONE && !reg_wdata_i[FLD_ARM])
		|=> ##1 !armed_o)
		else $error("Disarm not reflected");

	// Every other comparator register holds still while armed
	AST_LOCKED_CTL: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && dbg_ctl_one_reg[FLD_ARM]) |=> $stable(a_ctl_reg) && $stable(b_ctl_reg)
		&& $stable(c_ctl_reg) && $stable(d_ctl_reg) && $stable(pair_mode_reg))
		else $error("Control changed while armed");
	AST_LOCKED_DATA: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_write_i && dbg_ctl_one_reg[FLD_ARM])
		|=> $stable(a_data_reg) && $stable(a_addr_reg))
		else $error("A data or address changed while armed");

	// Opposite end byte lanes of the mask, B and D registers, and the reset value of D
	AST_MASK_LOW_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_A_MASK3) |=> a_mask_reg[7:0] == $past(reg_wdata_i))
		else $error("Mask low byte not written");
	AST_B_LOW_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_B_ADDRL) |=> b_addr_reg[7:0] == $past(reg_wdata_i))
		else $error("B low address byte not written");
	AST_D_HIGH_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_ok && reg_addr_i == OFS_D_ADDRH) |=> d_addr_reg[23:16] == $past(reg_wdata_i))
		else $error("D high address byte not written");
	AST_D_RESET_ZERO: assert property (@(posedge mclk_i)
		$fell(reset_i) |-> d_addr_reg == RST_ADDR)
		else $error("D address not cleared by reset");

	// Read port: data for one cycle after the strobe, zero otherwise
	AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (reset_i)
		!reg_read_i |=> reg_rdata_o == RST_BYTE)
		else $error("Read data not idle");
	AST_READ_MASK_TOP: assert property (@(posedge mclk_i) disable iff (reset_i)
		(reg_read_i && reg_addr_i == OFS_A_MASK0)
		|=> reg_rdata_o == $past(a_mask_reg[31:24]))
		else $error("Mask top byte read wrong");

	// Match qualification of A, B and D
	AST_DISABLED_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		!a_ctl_reg[FLD_COMP_EN] |=> !match_a_o)
		else $error("Disabled comparator A matched");
	AST_DISABLED_D: assert property (@(posedge mclk_i) disable iff (reset_i)
		!d_eff_ctl[FLD_COMP_EN] |=> !match_d_o)
		else $error("Disabled comparator D matched");
	AST_OPCODE_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		(a_ctl_reg[FLD_COMP_EN] && a_ctl_reg[FLD_OPCODE_SEL] && pc_valid_i
		&& pc_addr_i == a_addr_reg) |=> match_a_o)
		else $error("Opcode match of A missed");
	AST_OPCODE_D: assert property (@(posedge mclk_i) disable iff (reset_i)
		(d_eff_ctl[FLD_COMP_EN] && d_eff_ctl[FLD_OPCODE_SEL] && pc_valid_i
		&& pc_addr_i == d_addr_reg) |=> match_d_o)
		else $error("Opcode match of D missed");
	AST_ACCESS_MATCH: assert property (@(posedge mclk_i) disable iff (reset_i)
		(b_eff_ctl[FLD_COMP_EN] && !b_eff_ctl[FLD_OPCODE_SEL] && bus_valid_i
		&& bus_addr_i == b_addr_reg
		&& (!b_eff_ctl[FLD_ACCESS_EN] || bus_rw_i == b_eff_ctl[FLD_RW_VALUE])) |=> match_b_o)
		else $error("Qualified data access missed");

endmodule

// File: design/dbc_pkg.sv
// Package with register map, field positions and reset values of the debug comparators
package dbc_pkg;
	localparam int ADDR_W = 16;
	localparam int BUS_AW = 24;
	localparam int BUS_DW = 32;
	// Byte register offsets
	localparam logic [15:0] OFS_A_MASK0 = 16'h011C;
	localparam logic [15:0] OFS_A_MASK3 = 16'h011F;
	localparam logic [15:0] OFS_B_CTL = 16'h0120;
	localparam logic [15:0] OFS_B_ADDRH = 16'h0125;
	localparam logic [15:0] OFS_B_ADDRL = 16'h0127;
	localparam logic [15:0] OFS_D_CTL = 16'h0140;
	localparam logic [15:0] OFS_D_ADDRH = 16'h0145;
	localparam logic [15:0] OFS_D_ADDRL = 16'h0147;
	// Local registers for the outside-window controls
	localparam logic [15:0] OFS_DEBUG_CONTROL_ONE = 16'h0100;
	localparam logic [15:0] OFS_A_CTL = 16'h0110;
	localparam logic [15:0] OFS_A_DATA0 = 16'h0118;
	localparam logic [15:0] OFS_A_DATA3 = 16'h011B;
	localparam logic [15:0] OFS_C_CTL = 16'h0130;
	localparam logic [15:0] OFS_PAIR_MODE = 16'h0101;
	localparam logic [15:0] OFS_MATCH_STATUS = 16'h0102;
	// Control register fields
	localparam int FLD_OPCODE_SEL = 5;
	localparam int FLD_RW_VALUE = 3;
	localparam int FLD_ACCESS_EN = 2;
	localparam int FLD_COMP_EN = 0;
	localparam logic [7:0] CTL_WMASK = 8'h2D;
	// Arm bit in debug_control_one, pair mode fields
	localparam int FLD_ARM = 7;
	localparam int FLD_PAIR_AB = 0;
	localparam int FLD_PAIR_CD = 2;
	localparam logic [1:0] PAIR_RANGE = 2'h1;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [23:0] RST_ADDR = 24'h00_0000;
endpackage

// File: sim/dbc_cpu_model.sv
// Processor bus model: one data access or opcode fetch per request
`timescale 1ns/100ps
module dbc_cpu_model
	import dbc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic pc_kind_i,
	input wire logic [BUS_AW-1:0] addr_i,
	input wire logic [BUS_DW-1:0] data_i,
	input wire logic rw_i,
	output logic [BUS_AW-1:0] bus_addr_o,
	output logic [BUS_DW-1:0] bus_data_o,
	output logic bus_rw_o,
	output logic bus_valid_o,
	output logic [BUS_AW-1:0] pc_addr_o,
	output logic pc_valid_o
);
	// Idle lines show the inverse of the request inputs so stale values never look valid
	always @(posedge mclk_i) begin
		bus_valid_o <= go_i && !pc_kind_i;
		pc_valid_o <= go_i && pc_kind_i;
		bus_addr_o <= (go_i && !pc_kind_i) ? addr_i : ~addr_i;
		pc_addr_o <= (go_i && pc_kind_i) ? addr_i : ~addr_i;
		bus_data_o <= go_i ? data_i : ~data_i;
		bus_rw_o <= go_i ? rw_i : ~rw_i;
	end
endmodule

// File: sim/dbc_comparators_tb_top.sv
// Testbench for the debug comparators: register map, write lock and matching
`timescale 1ns/100ps
module dbc_comparators_tb_top;
	import dbc_pkg::*;
	logic mclk_i = 0;
	logic reset_i = 1;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_write_i = 0;
	logic reg_read_i = 0;
	logic go = 0;
	logic pck = 0;
	logic m_rw = 0;
	logic [23:0] m_addr = 24'h00_0000;
	logic [31:0] m_data = 32'h0000_0000;
	logic [7:0] reg_rdata_o;
	logic armed_o, match_a_o, match_b_o, match_d_o, bus_rw, bus_valid, pc_valid;
	logic [23:0] bus_addr, pc_addr;
	logic [31:0] bus_data, dv, mk;
	logic [7:0] ctl [4];
	logic [23:0] adr [4];
	logic [3:0] pair;
	logic arm;
	int n_fail = 0;
	int checked = 0;
	integer seed = 32'hefec;
	integer r;

	// Clock at 250 MHz
	always #2 mclk_i = ~mclk_i;

	dbc_cpu_model cpu (.mclk_i(mclk_i), .go_i(go), .pc_kind_i(pck), .addr_i(m_addr),
		.data_i(m_data), .rw_i(m_rw), .bus_addr_o(bus_addr), .bus_data_o(bus_data),
		.bus_rw_o(bus_rw), .bus_valid_o(bus_valid), .pc_addr_o(pc_addr), .pc_valid_o(pc_valid));
	dbc_comparators dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .bus_addr_i(bus_addr), .bus_data_i(bus_data),
		.bus_rw_i(bus_rw), .bus_valid_i(bus_valid), .pc_addr_i(pc_addr), .pc_valid_i(pc_valid),
		.armed_o(armed_o), .match_a_o(match_a_o), .match_b_o(match_b_o), .match_d_o(match_d_o));

	// Verdict and end of run
	task automatic report_and_stop();
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Shadow registers back to their reset values
	task automatic shadow_clear();
		ctl = '{default: 8'h00};
		adr = '{default: 24'h00_0000};
		{dv, mk, pair, arm} = '0;
	endtask
	// Shadow copy of the registers; comparator registers freeze while armed
	task automatic upd(input logic [15:0] a, input logic [7:0] d);
		int s;
		s = 8 * (3 - a[1:0]);
		if (a == OFS_DEBUG_CONTROL_ONE) begin
			arm = d[FLD_ARM];
		end else if (!arm && a[15:8] == 8'h01) begin
			if (a == OFS_PAIR_MODE) pair = d[3:0];
			if (a[3:0] == 4'h0 && a[7:4] inside {[4'h1:4'h4]}) ctl[a[7:4] - 1] = d & CTL_WMASK;
			if (a[3:0] inside {[4'h5:4'h7]} && a[7:4] inside {4'h1, 4'h2, 4'h4})
				adr[a[7:4] - 1][s +: 8] = d;
			if (a[7:2] == 6'h06) dv[s +: 8] = d;
			if (a[7:2] == 6'h07) mk[s +: 8] = d;
		end
	endtask
	// Expected read value in the comparator window
	function automatic logic [7:0] rexp(input logic [15:0] a);
		int s;
		s = 8 * (3 - a[1:0]);
		if (a == OFS_DEBUG_CONTROL_ONE) return {arm, 7'h00};
		if (a == OFS_PAIR_MODE) return {4'h0, pair};
		if (a[3:0] == 4'h0 && a[7:4] inside {[4'h1:4'h4]}) return ctl[a[7:4] - 1];
		if (a[3:0] inside {[4'h5:4'h7]} && a[7:4] inside {4'h1, 4'h2, 4'h4})
			return adr[a[7:4] - 1][s +: 8];
		if (a[7:2] == 6'h06) return dv[s +: 8];
		if (a[7:2] == 6'h07) return mk[s +: 8];
		return 8'h00;
	endfunction
	// Address and access-type part of a match
	function automatic logic hit(input logic [7:0] c, input logic [23:0] a, input logic pk,
		input logic [23:0] ad, input logic rw);
		return c[0] && ad == a && (c[5] ? pk : !pk && (!c[2] || rw == c[3]));
	endfunction
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge mclk_i);
		reg_write_i <= 1'b0;
		upd(a, d);
	endtask
	// Reads every byte of the window, unmapped ones included
	task automatic rd_all();
		for (int a = 16'h0100; a < 16'h0150; a++) begin
			@(posedge mclk_i);
			reg_addr_i <= a[15:0];
			reg_read_i <= 1'b1;
			@(posedge mclk_i);
			reg_read_i <= 1'b0;
			#1 chk8("reg_rdata_o", rexp(a[15:0]), reg_rdata_o);
		end
		@(posedge mclk_i);
		#1 chk8("reg_rdata_o idle", 8'h00, reg_rdata_o);
	endtask
	task automatic scramble(input int n, input logic bias);
		for (int a = 16'h0110; a < 16'h0110 + n; a++) begin
			r = $random(seed);
			wr(bias ? a[15:0] : 16'h0110 + r[5:0], r[7:0] | {7'h00, bias & r[8]});
		end
	endtask
	// One bus cycle aimed at a comparator address half of the time
	task automatic cyc();
		logic pk, rw;
		logic [23:0] ad;
		logic [31:0] da;
		logic [7:0] cb, cd;
		logic ea, eb, ed;
		r = $random(seed);
		pk = r[0];
		rw = r[1];
		ad = r[3] ? adr[r[5:4] == 2'h2 ? 3 : r[4]] : r[31:8];
		da = r[2] ? dv ^ ($random(seed) & ~mk) : $random(seed);
		@(posedge mclk_i);
		go <= 1'b1;
		pck <= pk;
		m_rw <= rw;
		m_addr <= ad;
		m_data <= da;
		@(posedge mclk_i);
		go <= 1'b0;
		cb = pair[1:0] == PAIR_RANGE ? ctl[0] : ctl[1];
		cd = pair[3:2] == PAIR_RANGE ? ctl[2] : ctl[3];
		ea = hit(ctl[0], adr[0], pk, ad, rw)
			&& (ctl[0][FLD_OPCODE_SEL] || ((da ^ dv) & mk) == 0);
		eb = hit(cb, adr[1], pk, ad, rw);
		ed = hit(cd, adr[3], pk, ad, rw);
		// Matches stand after this edge; the status byte is read while they stand
		@(posedge mclk_i);
		reg_addr_i <= OFS_MATCH_STATUS;
		reg_read_i <= 1'b1;
		#1 chk1("match_a_o", ea, match_a_o);
		chk1("match_b_o", eb, match_b_o);
		chk1("match_d_o", ed, match_d_o);
		@(posedge mclk_i);
		reg_read_i <= 1'b0;
		#1 chk8("match status", {5'h00, ed, eb, ea}, reg_rdata_o);
	endtask

	// Watchdog
	initial begin
		#(4 * 20000);
		n_fail++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		shadow_clear();
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd_all();
		scramble(80, 1'b0);
		rd_all();
		for (int p = 0; p < 16; p++) begin
			wr(OFS_PAIR_MODE, p[7:0]);
			scramble(64, 1'b1);
			repeat (24) cyc();
		end
		wr(OFS_DEBUG_CONTROL_ONE, 8'h80);
		@(posedge mclk_i);
		#1 chk1("armed_o", 1'b1, armed_o);
		scramble(64, 1'b1);
		rd_all();
		repeat (24) cyc();
		wr(OFS_DEBUG_CONTROL_ONE, 8'h00);
		@(posedge mclk_i);
		#1 chk1("armed_o", 1'b0, armed_o);
		scramble(64, 1'b1);
		rd_all();
		// Reset in mid-run while armed clears every register and the arm bit
		wr(OFS_DEBUG_CONTROL_ONE, 8'h80);
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		shadow_clear();
		#1 chk1("armed_o", 1'b0, armed_o);
		rd_all();
		report_and_stop();
	end
endmodule
